// *** hdl/sbo_pkg.sv ***
package sbo_pkg;

  // Processor commands placed on the command lines
  typedef enum logic [2:0] {
    SBO_NOP,
    SBO_READ_MISS,
    SBO_WRITE_BLOCK,
    SBO_WRITE_LOCKED,
    SBO_BOARD_VICTIM,
    SBO_SET_DIRTY
  } sbo_cmd_t;

  // Requests sent by the system logic
  typedef enum logic [2:0] {
    SBO_SYS_NOP,
    SBO_SYS_READ,
    SBO_SYS_READ_DIRTY,
    SBO_SYS_INVALIDATE,
    SBO_SYS_SET_SHARED
  } sbo_sys_t;

  typedef enum logic [2:0] {
    SBO_FREE,
    SBO_AT_PADS,
    SBO_DATA,
    SBO_QUIESCE,
    SBO_HUNG
  } sbo_state_t;

  localparam int SBO_ADDR_W = 36;
  localparam int SBO_BLOCK_BYTES = 64;
  localparam int SBO_BEAT_BYTES = 16;
  localparam int SBO_BLOCK_BEATS = SBO_BLOCK_BYTES / SBO_BEAT_BYTES;
  localparam int SBO_LOCKED_BEATS = 2;
  localparam int SBO_BEAT_W = 3;
  localparam int SBO_FILL_W = 3;
  localparam int SBO_MAX_FILLS = 2;
  localparam int SBO_FIFO_DEPTH = 8;
  // Low address bits that select a beat inside one block
  localparam int SBO_BLOCK_LSB = 2;

  localparam int SBO_CLK_NS = 10;
  localparam int SBO_SYS_RESP_NS = 40;
  localparam int SBO_TMR_W = 4;
  localparam int SBO_SYS_RESP_CYC =
    (SBO_SYS_RESP_NS + SBO_CLK_NS - 1) / SBO_CLK_NS;

endpackage

// *** hdl/sbo_fifo.sv ***
`timescale 1ns/100ps
module sbo_fifo
  import sbo_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = SBO_FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
  } sbo_fifo_t;

  sbo_fifo_t s;
  sbo_fifo_t next_s;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = s.room;
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rp];
  assign push = in_valid && s.room;
  assign pop = out_ready && out_valid;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = bump(s.wp);
    end
    if (pop)
    begin
      next_s.rp = bump(s.rp);
    end
    if (push && !pop)
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      next_s.cnt = s.cnt - 1'b1;
    end
    // Registered so that the source sees ready straight from a flop
    next_s.room = (next_s.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.room <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule // sbo_fifo

// *** hdl/sbo_biu.sv ***
// Behaviour
// - fills may run back to back
// - no board cache: serve requests immediately
// - board cache: delay requests until quiesced
// - locked write fails cleanly otherwise
// - issue only without idle or system requests
// - fill pending: only further read misses
// - idle or system command withdraws command
// - idle ends when released and all answered
// - victimless read miss stays loaded anyway
// - ack beats idle in same cycle
// - miss with victim pair is atomic
// - reissue interrupted command unless displaced
`timescale 1ns/100ps
module sbo_biu
  import sbo_pkg::*;
#(
  parameter int ADDR_W = SBO_ADDR_W,
  parameter int DEPTH = SBO_FIFO_DEPTH,
  parameter int MAX_FILLS = SBO_MAX_FILLS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic board_cache_enabled,
  input wire logic victim_first,
  input wire logic proc_valid,
  output logic proc_ready,
  input wire sbo_cmd_t proc_cmd,
  input wire logic [ADDR_W-1:0] proc_addr,
  input wire logic proc_victim,
  input wire logic [ADDR_W-1:0] proc_victim_addr,
  output sbo_cmd_t cmd_lines,
  output logic [ADDR_W-1:0] cmd_addr,
  input wire logic cmd_ack,
  input wire logic cmd_fail,
  input wire logic data_ack,
  input wire logic fill_start,
  input wire logic cache_idle_req,
  input wire logic sys_valid,
  input wire sbo_sys_t sys_cmd,
  input wire logic [ADDR_W-1:0] sys_addr,
  output logic sys_resp,
  output logic proc_done,
  output logic proc_failed,
  output logic proc_dropped,
  output logic fill_done,
  output logic biu_idle,
  output logic biu_hung
);

  localparam int CW = $bits(sbo_cmd_t);
  localparam int QW = CW + 1 + 2 * ADDR_W;

  typedef struct packed {
    sbo_state_t st;
    sbo_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic pair2;
    sbo_cmd_t cmd2;
    logic [ADDR_W-1:0] addr2;
    logic pair_on;
    logic cack_seen;
    logic [SBO_BEAT_W-1:0] beats;
    logic retry;
    logic kill;
    logic [SBO_FILL_W-1:0] fills;
    logic fill_on;
    logic [SBO_BEAT_W-1:0] fill_beats;
    logic sys_pend;
    sbo_sys_t sys_code;
    logic [ADDR_W-1:0] sys_blk;
    logic [SBO_TMR_W-1:0] sys_tmr;
    sbo_cmd_t cmd_out;
    logic [ADDR_W-1:0] addr_out;
    logic done;
    logic failed;
    logic dropped;
    logic fill_end;
    logic sys_resp;
    logic hung;
    logic idle;
  } sbo_biu_t;

  sbo_biu_t s;
  sbo_biu_t next_s;
  logic q_valid;
  logic q_ready;
  logic [QW-1:0] q_data;
  sbo_cmd_t h_cmd;
  logic h_vic;
  logic [ADDR_W-1:0] h_addr;
  logic [ADDR_W-1:0] h_vaddr;
  logic sys_take;
  logic sys_go;
  logic quiesce_req;
  logic can_issue;
  logic miss_alone;

  sbo_fifo #(.WIDTH(QW), .DEPTH(DEPTH)) u_req_q (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(proc_valid),
    .in_ready(proc_ready),
    .in_data({proc_cmd, proc_victim, proc_addr, proc_victim_addr}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  assign h_cmd = sbo_cmd_t'(q_data[QW-1 -: CW]);
  assign h_vic = q_data[2 * ADDR_W];
  assign h_addr = q_data[2 * ADDR_W - 1 -: ADDR_W];
  assign h_vaddr = q_data[ADDR_W-1:0];

  function automatic logic [SBO_BEAT_W-1:0] beats_of(input sbo_cmd_t c);
    case (c)
      SBO_WRITE_BLOCK, SBO_BOARD_VICTIM:
        beats_of = SBO_BEAT_W'(SBO_BLOCK_BEATS);
      SBO_WRITE_LOCKED: beats_of = SBO_BEAT_W'(SBO_LOCKED_BEATS);
      default: beats_of = '0;
    endcase
  endfunction

  function automatic logic same_block(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] b);
    same_block = (a[ADDR_W-1:SBO_BLOCK_LSB] == b[ADDR_W-1:SBO_BLOCK_LSB]);
  endfunction

  assign sys_take = sys_valid && (sys_cmd != SBO_SYS_NOP) && !s.sys_pend;
  assign quiesce_req = cache_idle_req || sys_valid || s.sys_pend;
  // With a board cache probes wait for a quiet interface; without one
  // they run at once and the system must avoid the block races
  assign sys_go = s.sys_pend && !s.pair_on &&
    (board_cache_enabled ? (s.st == SBO_QUIESCE) : 1'b1);
  assign miss_alone = (s.cmd == SBO_READ_MISS) && !s.pair2 && !s.pair_on;
  assign can_issue = (s.st == SBO_FREE) && !quiesce_req && q_valid &&
    ((s.fills == '0) || (h_cmd == SBO_READ_MISS)) &&
    (s.fills != SBO_FILL_W'(MAX_FILLS));
  assign q_ready = can_issue;

  assign cmd_lines = s.cmd_out;
  assign cmd_addr = s.addr_out;
  assign sys_resp = s.sys_resp;
  assign proc_done = s.done;
  assign proc_failed = s.failed;
  assign proc_dropped = s.dropped;
  assign fill_done = s.fill_end;
  assign biu_idle = s.idle;
  assign biu_hung = s.hung;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.failed = 1'b0;
    next_s.dropped = 1'b0;
    next_s.fill_end = 1'b0;
    next_s.sys_resp = 1'b0;

    // Fill data beats; a new fill may start on the last beat
    if (s.fill_on && data_ack)
    begin
      next_s.fill_beats = s.fill_beats + 1'b1;
      if (s.fill_beats == SBO_BEAT_W'(SBO_BLOCK_BEATS - 1))
      begin
        next_s.fill_end = 1'b1;
        next_s.fill_beats = '0;
        next_s.fills = s.fills - 1'b1;
        next_s.fill_on = fill_start && (s.fills > SBO_FILL_W'(1));
      end
    end
    else if (!s.fill_on && fill_start && (s.fills != '0))
    begin
      next_s.fill_on = 1'b1;
    end

    // System request buffer
    if (sys_take)
    begin
      next_s.sys_pend = 1'b1;
      next_s.sys_code = sys_cmd;
      next_s.sys_blk = sys_addr;
      next_s.sys_tmr = SBO_TMR_W'(SBO_SYS_RESP_CYC - 1);
    end
    if (sys_go)
    begin
      if (s.sys_tmr == '0)
      begin
        next_s.sys_pend = 1'b0;
        next_s.sys_resp = 1'b1;
      end
      else
      begin
        next_s.sys_tmr = s.sys_tmr - 1'b1;
      end
    end

    case (s.st)
      SBO_FREE:
      begin
        if (can_issue)
        begin
          next_s.st = SBO_AT_PADS;
          next_s.pair2 = h_vic && (h_cmd == SBO_READ_MISS);
          next_s.cmd = (h_vic && victim_first) ? SBO_BOARD_VICTIM : h_cmd;
          next_s.addr = (h_vic && victim_first) ? h_vaddr : h_addr;
          next_s.cmd2 = victim_first ? SBO_READ_MISS : SBO_BOARD_VICTIM;
          next_s.addr2 = victim_first ? h_addr : h_vaddr;
          next_s.cmd_out = next_s.cmd;
          next_s.addr_out = next_s.addr;
          next_s.beats = '0;
          next_s.cack_seen = 1'b0;
        end
        else if (quiesce_req)
        begin
          next_s.st = SBO_QUIESCE;
        end
      end
      SBO_AT_PADS, SBO_DATA:
      begin
        // Write data may be acknowledged ahead of the command
        if (data_ack && !s.fill_on && (beats_of(s.cmd) != '0))
        begin
          next_s.beats = s.beats + 1'b1;
        end
        if (cmd_ack)
        begin
          next_s.cack_seen = 1'b1;
          next_s.pair_on = s.pair2 || s.pair_on;
          if (s.cmd == SBO_READ_MISS)
          begin
            // Keeps a fill that ends in this same cycle
            next_s.fills = next_s.fills + 1'b1;
          end
        end
        if (s.cmd == SBO_WRITE_LOCKED && cmd_ack && cmd_fail)
        begin
          if (data_ack && s.beats == '0)
          begin
            next_s.st = SBO_HUNG;
            next_s.cmd_out = SBO_NOP;
          end
          else
          begin
            next_s.failed = 1'b1;
            next_s.st = SBO_FREE;
            next_s.pair_on = 1'b0;
            next_s.cmd_out = SBO_NOP;
          end
        end
        else if ((s.cack_seen || cmd_ack) &&
                 (next_s.beats == beats_of(s.cmd)))
        begin
          if (s.pair2)
          begin
            // Second half goes out at once; idle cannot split the pair
            next_s.pair2 = 1'b0;
            next_s.cmd = s.cmd2;
            next_s.addr = s.addr2;
            next_s.cmd_out = s.cmd2;
            next_s.addr_out = s.addr2;
            next_s.beats = '0;
            next_s.cack_seen = 1'b0;
            next_s.st = SBO_AT_PADS;
          end
          else
          begin
            next_s.done = 1'b1;
            next_s.pair_on = 1'b0;
            next_s.cmd_out = SBO_NOP;
            next_s.st = SBO_FREE;
          end
        end
        else if (cmd_ack || s.cack_seen)
        begin
          next_s.st = SBO_DATA;
          next_s.cmd_out = SBO_NOP;
        end
        else if (quiesce_req && !s.pair_on && !miss_alone)
        begin
          next_s.st = SBO_QUIESCE;
          next_s.cmd_out = SBO_NOP;
          next_s.retry = 1'b1;
          next_s.kill = 1'b0;
          next_s.beats = '0;
        end
        // A victimless miss stays loaded through idle until taken
      end
      SBO_QUIESCE:
      begin
        if (!cache_idle_req && !s.sys_pend && !sys_valid)
        begin
          next_s.retry = 1'b0;
          next_s.kill = 1'b0;
          if (s.retry && !s.kill)
          begin
            next_s.st = SBO_AT_PADS;
            next_s.cmd_out = s.cmd;
            next_s.addr_out = s.addr;
          end
          else
          begin
            next_s.dropped = s.retry;
            next_s.pair2 = 1'b0;
            next_s.st = SBO_FREE;
          end
        end
      end
      SBO_HUNG:
      begin
        next_s.hung = 1'b1;
      end
      default:
      begin
        next_s.st = SBO_FREE;
      end
    endcase

    // After the state update, so that the request that starts the
    // idle can already cancel the retry of the command it interrupts
    if (sys_take && next_s.retry)
    begin
      if ((sys_cmd != SBO_SYS_READ) && same_block(sys_addr, s.addr))
      begin
        next_s.kill = 1'b1;
      end
      if (!board_cache_enabled && (s.cmd == SBO_WRITE_BLOCK))
      begin
        next_s.kill = 1'b1;
      end
    end
    next_s.idle = (next_s.st == SBO_QUIESCE);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_no_issue_idle: assert property (
    (s.st == SBO_FREE && cache_idle_req) |=> s.cmd_out == SBO_NOP)
    else $error("command issued while idle requested");

  chk_fill_miss_only: assert property (
    (s.st == SBO_FREE && s.fills != '0) |=>
    (s.cmd_out inside {SBO_NOP, SBO_READ_MISS, SBO_BOARD_VICTIM}))
    else $error("wrong command issued under pending fill");

  chk_withdraw_cmd: assert property (
    (s.st == SBO_AT_PADS && cache_idle_req && !cmd_ack && !s.cack_seen &&
     !s.pair_on && !miss_alone) |=> (s.cmd_out == SBO_NOP && biu_idle))
    else $error("command not withdrawn on idle");

  chk_miss_stays: assert property (
    (s.st == SBO_AT_PADS && miss_alone && cache_idle_req && !cmd_ack) |=>
    (s.cmd_out == SBO_READ_MISS && s.st == SBO_AT_PADS))
    else $error("victimless miss withdrawn");

  chk_idle_holds: assert property (
    (biu_idle && (cache_idle_req || s.sys_pend)) |=> biu_idle)
    else $error("idle ended early");

  chk_ack_wins: assert property (
    (s.st == SBO_AT_PADS && cmd_ack && cache_idle_req && !cmd_fail) |=>
    (!biu_idle && !s.retry))
    else $error("ack lost against idle");

  chk_pair_blocks: assert property (
    (s.pair_on && s.sys_pend) |=> (s.sys_tmr == $past(s.sys_tmr) && !sys_resp))
    else $error("system request served inside pair");

  chk_bc_delay: assert property (
    (board_cache_enabled && s.sys_pend && !biu_idle) |=> !sys_resp)
    else $error("request served before quiesce");

  chk_fast_probe: assert property (
    (!board_cache_enabled && s.sys_pend && !s.pair_on && s.sys_tmr != '0)
    |=> s.sys_tmr == $past(s.sys_tmr) - 1'b1)
    else $error("fast probe stalled");

  chk_lock_fail: assert property (
    (s.st == SBO_AT_PADS && s.cmd == SBO_WRITE_LOCKED && cmd_ack && cmd_fail &&
     !data_ack) |=> (proc_failed && s.st == SBO_FREE))
    else $error("locked write not failed cleanly");

  chk_reissue: assert property (
    (biu_idle && !cache_idle_req && !s.sys_pend && !sys_valid && s.retry &&
     !s.kill) |=> (s.st == SBO_AT_PADS && s.cmd_out == $past(s.cmd)))
    else $error("interrupted command not reissued");

  chk_fill_chain: assert property (
    (s.fill_on && data_ack && fill_start && s.fills > SBO_FILL_W'(1) &&
     s.fill_beats == SBO_BEAT_W'(SBO_BLOCK_BEATS - 1)) |=> s.fill_on)
    else $error("back to back fill lost");

endmodule // sbo_biu

// *** tb/sbo_sys_model.sv ***
`timescale 1ns/100ps
module sbo_sys_model
  import sbo_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire sbo_cmd_t cmd_lines,
  input wire logic hold,
  input wire logic fill_go,
  input wire logic [1:0] lock_fail,
  output logic cmd_ack,
  output logic cmd_fail,
  output logic data_ack,
  output logic fill_start
);
  int beat;
  int fills;
  int fbeat;
  logic cool;

  // Mode 1 fails a locked write with no data, mode 3 on its first beat
  function automatic int need(input sbo_cmd_t c);
    if (c == SBO_READ_MISS || c == SBO_SET_DIRTY)
      return 0;
    if (c == SBO_WRITE_LOCKED)
      return (lock_fail == 2'h1) ? 0 : (lock_fail == 2'h3) ? 1 : 2;
    return SBO_BLOCK_BEATS;
  endfunction

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {cmd_ack, cmd_fail, data_ack, fill_start, cool} <= 5'h00;
      beat <= 0;
      fills <= 0;
      fbeat <= 0;
    end
    else
    begin
      {cmd_ack, cmd_fail, data_ack, fill_start} <= 4'h0;
      if (cmd_lines == SBO_NOP)
        beat <= 0;
      if (cool)
      begin
        // The pads still show the command one cycle after its final ack
        cool <= 1'b0;
        beat <= 0;
      end
      else if (fbeat != 0)
      begin
        data_ack <= 1'b1;
        if (fbeat < SBO_BLOCK_BEATS)
          fbeat <= fbeat + 1;
        else
        begin
          fills <= fills - 1;
          fill_start <= fills > 1;
          fbeat <= (fills > 1) ? 1 : 0;
          cool <= fills == 1;
        end
      end
      // Only a loaded command is acked, never one withdrawn by idling
      else if (cmd_lines != SBO_NOP && !hold)
      begin
        if (beat + 1 >= need(cmd_lines))
        begin
          cmd_ack <= 1'b1;
          data_ack <= need(cmd_lines) != 0;
          cmd_fail <= cmd_lines == SBO_WRITE_LOCKED &&
            lock_fail != 2'h0;
          fills <= fills + ((cmd_lines == SBO_READ_MISS) ? 1 : 0);
          cool <= 1'b1;
        end
        else
        begin
          data_ack <= 1'b1;
          beat <= beat + 1;
        end
      end
      else if (fills != 0 && fill_go)
      begin
        fill_start <= 1'b1;
        fbeat <= 1;
      end
    end
  end
endmodule // sbo_sys_model

// *** tb/system_bus_request_ordering_test.sv ***
`timescale 1ns/100ps
module system_bus_request_ordering_test import sbo_pkg::*;;
  logic clk, sys_rst, board_cache_enabled, victim_first, proc_valid;
  logic proc_ready, proc_victim, cmd_ack, cmd_fail, data_ack, fill_start;
  logic cache_idle_req, sys_valid, sys_resp, proc_done, proc_failed;
  logic proc_dropped, fill_done, biu_idle, biu_hung, hold, fill_go;
  logic [1:0] lock_fail;
  logic [SBO_ADDR_W-1:0] proc_addr, sys_addr, cmd_addr;
  sbo_cmd_t proc_cmd, cmd_lines, want;
  sbo_sys_t sys_cmd;
  int miscompares, num_checks, waited;

  sbo_biu i_sbo_biu (.clk(clk), .sys_rst(sys_rst),
    .board_cache_enabled(board_cache_enabled), .victim_first(victim_first),
    .proc_valid(proc_valid), .proc_ready(proc_ready), .proc_cmd(proc_cmd),
    .proc_addr(proc_addr), .proc_victim(proc_victim),
    .proc_victim_addr(proc_addr ^ 36'h000100000), .cmd_lines(cmd_lines),
    .cmd_addr(cmd_addr), .cmd_ack(cmd_ack), .cmd_fail(cmd_fail),
    .data_ack(data_ack), .fill_start(fill_start),
    .cache_idle_req(cache_idle_req), .sys_valid(sys_valid),
    .sys_cmd(sys_cmd), .sys_addr(sys_addr), .sys_resp(sys_resp),
    .proc_done(proc_done), .proc_failed(proc_failed),
    .proc_dropped(proc_dropped), .fill_done(fill_done),
    .biu_idle(biu_idle), .biu_hung(biu_hung));

  sbo_sys_model i_sbo_sys_model (.clk(clk), .sys_rst(sys_rst),
    .cmd_lines(cmd_lines), .hold(hold), .fill_go(fill_go),
    .lock_fail(lock_fail), .cmd_ack(cmd_ack), .cmd_fail(cmd_fail),
    .data_ack(data_ack), .fill_start(fill_start));

  always #5 clk = ~clk;

  task automatic end_of_test;
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] e,
    input logic [35:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
      miscompares++;
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return proc_done;
      1: return fill_done;
      2: return sys_resp;
      3: return proc_failed;
      4: return biu_hung;
      5: return proc_dropped;
      6: return !biu_idle;
      default: return cmd_lines == want;
    endcase
  endfunction

  task automatic cyc(input int k);
    repeat (k)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic wait_hi(input int s);
    waited = 0;
    do
    begin
      cyc(1);
      waited++;
    end
    while (pick(s) !== 1'b1 && waited < 700);
    if (waited >= 700)
    begin
      chk("wait", 36'h1, 36'h0);
      end_of_test();
    end
  endtask

  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
  endtask

  // Request stays up until the edge that samples ready high
  task automatic offer(input sbo_cmd_t c, input logic v);
    int n;
    n = 0;
    proc_valid <= 1'b1;
    proc_cmd <= c;
    proc_victim <= v;
    proc_addr <= proc_addr + 36'h40;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (proc_ready !== 1'b1 && n < 300);
    proc_valid <= 1'b0;
    if (proc_ready !== 1'b1)
    begin
      chk("proc_ready", 36'h1, 36'h0);
      end_of_test();
    end
    #1;
  endtask

  task automatic run_one(input sbo_cmd_t c, input logic [1:0] m,
    input int s);
    lock_fail <= m;
    offer(c, 1'b0);
    want = c;
    wait_hi(7);
    wait_hi(s);
    if (s != 4)
      chk("cmd_lines", SBO_NOP, cmd_lines);
    lock_fail <= 2'h0;
  endtask

  task automatic t_fill;
    int bad;
    bad = 0;
    fill_go <= 1'b0;
    offer(SBO_READ_MISS, 1'b0);
    offer(SBO_READ_MISS, 1'b0);
    offer(SBO_WRITE_BLOCK, 1'b0);
    repeat (30)
    begin
      cyc(1);
      bad += (cmd_lines == SBO_WRITE_BLOCK);
    end
    chk("write under fill", 36'h0, 36'(bad));
    fill_go <= 1'b1;
    wait_hi(1);
    wait_hi(1);
    chk("fill gap", 36'h4, 36'(waited));
    want = SBO_WRITE_BLOCK;
    wait_hi(7);
    wait_hi(0);
  endtask

  task automatic t_idle;
    hold <= 1'b1;
    offer(SBO_WRITE_BLOCK, 1'b0);
    want = SBO_WRITE_BLOCK;
    wait_hi(7);
    cache_idle_req <= 1'b1;
    cyc(2);
    chk("withdrawn", SBO_NOP, cmd_lines);
    chk("idle", 36'h1, biu_idle);
    hold <= 1'b0;
    cyc(5);
    chk("idle held", 36'h1, biu_idle);
    cache_idle_req <= 1'b0;
    wait_hi(6);
    chk("reissue", SBO_WRITE_BLOCK, cmd_lines);
    wait_hi(0);
  endtask

  // Ack and idle request reach the block on the same edge
  task automatic t_race;
    hold <= 1'b1;
    offer(SBO_SET_DIRTY, 1'b0);
    want = SBO_SET_DIRTY;
    wait_hi(7);
    hold <= 1'b0;
    cyc(1);
    cache_idle_req <= 1'b1;
    wait_hi(0);
    cache_idle_req <= 1'b0;
    wait_hi(6);
  endtask

  task automatic t_miss_idle;
    hold <= 1'b1;
    offer(SBO_READ_MISS, 1'b0);
    want = SBO_READ_MISS;
    wait_hi(7);
    cache_idle_req <= 1'b1;
    cyc(3);
    chk("miss kept", SBO_READ_MISS, cmd_lines);
    hold <= 1'b0;
    wait_hi(0);
    cache_idle_req <= 1'b0;
    wait_hi(1);
  endtask

  task automatic t_pair(input logic vf);
    sbo_cmd_t second;
    logic [SBO_ADDR_W-1:0] vaddr;
    second = vf ? SBO_READ_MISS : SBO_BOARD_VICTIM;
    victim_first <= vf;
    fill_go <= 1'b0;
    offer(SBO_READ_MISS, 1'b1);
    vaddr = proc_addr ^ 36'h000100000;
    want = vf ? SBO_BOARD_VICTIM : SBO_READ_MISS;
    wait_hi(7);
    chk("first addr", vf ? vaddr : proc_addr, cmd_addr);
    want = second;
    wait_hi(7);
    chk("second addr", vf ? proc_addr : vaddr, cmd_addr);
    hold <= 1'b1;
    cache_idle_req <= 1'b1;
    cyc(3);
    chk("pair kept", second, cmd_lines);
    chk("pair idle", 36'h0, biu_idle);
    hold <= 1'b0;
    wait_hi(0);
    cache_idle_req <= 1'b0;
    fill_go <= 1'b1;
    wait_hi(1);
  endtask

  task automatic t_sys(input logic b, input sbo_sys_t sc, input int s);
    board_cache_enabled <= b;
    hold <= 1'b1;
    offer(SBO_WRITE_BLOCK, 1'b0);
    want = SBO_WRITE_BLOCK;
    wait_hi(7);
    sys_valid <= 1'b1;
    sys_cmd <= sc;
    // Target is still at the pads, never a block in transit
    sys_addr <= proc_addr;
    @(posedge clk);
    sys_valid <= 1'b0;
    wait_hi(2);
    if (b)
      chk("slow answer", 36'h1, 36'(waited >= 4));
    else
      chk("fast answer", 36'h4, 36'(waited));
    hold <= 1'b0;
    wait_hi(s);
  endtask

  task automatic t_fifo;
    int n;
    int d;
    n = 0;
    d = 0;
    hold <= 1'b1;
    proc_cmd <= SBO_WRITE_BLOCK;
    proc_victim <= 1'b0;
    proc_valid <= 1'b1;
    do
    begin
      @(posedge clk);
      n += (proc_ready === 1'b1);
      proc_addr <= proc_addr + 36'h40;
    end
    while (proc_ready === 1'b1 && n < 20);
    proc_valid <= 1'b0;
    chk("accepted", 36'(SBO_FIFO_DEPTH + 1), 36'(n));
    // Far side stalls two cycles in four while the buffer drains
    for (int k = 0; k < 800 && d < n; k++)
    begin
      hold <= k[1];
      cyc(1);
      d += (proc_done === 1'b1);
    end
    hold <= 1'b0;
    chk("drained", 36'(n), 36'(d));
  endtask

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {board_cache_enabled, victim_first, proc_valid, proc_victim} = 4'h0;
    {cache_idle_req, sys_valid, hold, lock_fail} = 5'h00;
    fill_go = 1'b1;
    proc_cmd = SBO_NOP;
    sys_cmd = SBO_SYS_NOP;
    proc_addr = 36'h000000000;
    sys_addr = 36'h000000000;
    miscompares = 0;
    num_checks = 0;
    do_reset();
    run_one(SBO_WRITE_BLOCK, 2'h0, 0);
    run_one(SBO_SET_DIRTY, 2'h0, 0);
    run_one(SBO_WRITE_LOCKED, 2'h0, 0);
    run_one(SBO_WRITE_LOCKED, 2'h1, 3);
    run_one(SBO_WRITE_LOCKED, 2'h2, 3);
    t_fill();
    t_idle();
    t_race();
    t_miss_idle();
    t_pair(1'b0);
    t_pair(1'b1);
    t_sys(1'b0, SBO_SYS_SET_SHARED, 5);
    for (int i = 1; i < 5; i++)
      t_sys(1'b1, sbo_sys_t'(i), (i == 1) ? 0 : 5);
    board_cache_enabled <= 1'b0;
    t_fifo();
    run_one(SBO_WRITE_LOCKED, 2'h3, 4);
    do_reset();
    run_one(SBO_WRITE_BLOCK, 2'h0, 0);
    end_of_test();
  end
endmodule // system_bus_request_ordering_test
